/* File: tmf_temperature_measure_format.sv */
`timescale 1ns/1ps
`default_nettype none
module tmf_temperature_measure_format #(
  parameter int ADC_W      = 16,
  parameter int TQ_W       = 12,
  parameter int DV1_GAIN   = 2,
  parameter int DV2_GAIN   = 1,
  parameter int CALC_SHIFT = 0
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // AXI4-Lite write
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [tmf_pkg::ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // AXI4-Lite read
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [tmf_pkg::ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // Analog front end
  output logic                   adcStart,
  output logic [1:0]             biasSel,
  output logic [1:0]             chanSel,
  output logic                   secondDiodeMode,
  output logic                   analogInFirstThermistor,
  output logic                   analogInSecondThermistor,
  input  wire logic              adcDone,
  input  wire logic [ADC_W-1:0]  adcData
);
  import tmf_pkg::*;

  localparam int ACC_W = TQ_W + AVG_LOG2;

  if (ADC_W < 8 || ADC_W > 24 || TQ_W < 10 || TQ_W > 16) begin : gBadParam
    $error("tmf: ADC_W or TQ_W out of supported range");
  end

  typedef struct packed {
    tmf_state_e                st;
    logic [1:0]                step;
    tmf_chan_e                 ch;
    tmf_bias_e                 bias;
    logic                      adcStart;
    logic [3:0][ADC_W-1:0]     smp;
    logic [2:0][ACC_W-1:0]     acc;
    logic [2:0][AVG_LOG2-1:0]  cnt;
    logic [7:0]                cfg1;
    logic [7:0]                cfg2;
    logic [7:0]                cfg3;
    logic [7:0]                remTemp;
    logic [7:0]                locTemp;
    logic [7:0]                rem2Temp;
    logic [1:0]                remFrac;
    logic [1:0]                locFrac;
    logic                      awHeld;
    logic [ADDR_W-1:0]         awAddr;
    logic                      wHeld;
    logic [7:0]                wByte;
    logic                      wLane;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } tmf_regs_s;

  tmf_regs_s s_q;
  tmf_regs_s s_d;

  // Byte code in [9:2], fraction in [1:0]
  function automatic logic [9:0] fmtTemp(input logic signed [TQ_W-1:0] tq, input logic ext);
    logic signed [TQ_W-1:0] ti;
    logic signed [TQ_W-1:0] v;
    logic [9:0]             r;
    ti = tq >>> FRAC_W;
    v  = ti + TQ_W'(EXT_OFFSET);
    r  = {8'h00, tq[FRAC_W-1:0]};
    if (ext) begin
      if (v < 0) begin
        r = 10'h000;
      end else if (v > EXT_MAX) begin
        r = {8'(EXT_MAX), 2'h0};
      end else begin
        r = {v[7:0], tq[FRAC_W-1:0]};
      end
    end else begin
      if (tq <= 0) begin
        r = 10'h000;
      end else if (ti > BIN_MAX) begin
        r = {8'(BIN_MAX), 2'h0};
      end else begin
        r = {ti[7:0], tq[FRAC_W-1:0]};
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] readReg(input tmf_regs_s s, input logic [ADDR_W-1:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      ADDR_CFG1:       d[7:0] = s.cfg1;
      ADDR_CFG2:       d[7:0] = s.cfg2;
      ADDR_CFG3:       d[7:0] = s.cfg3;
      ADDR_EXT_REMOTE: d[1:0] = s.remFrac;
      ADDR_EXT_LOCAL:  d[1:0] = s.locFrac;
      ADDR_REMOTE2:    d[7:0] = s.rem2Temp;
      ADDR_REMOTE:     d[7:0] = s.remTemp;
      ADDR_LOCAL:      d[7:0] = s.locTemp;
      default:         d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_CFG1 || a == ADDR_CFG2 || a == ADDR_CFG3 || a == ADDR_EXT_REMOTE
        || a == ADDR_EXT_LOCAL || a == ADDR_REMOTE2 || a == ADDR_REMOTE || a == ADDR_LOCAL;
  endfunction

  logic                    diode2En;
  logic                    avgOff;
  logic                    extRange;
  logic signed [ADC_W:0]   dv1;
  logic signed [ADC_W:0]   dv2;
  logic signed [31:0]      prod;
  logic signed [TQ_W-1:0]  tq;
  logic signed [ACC_W-1:0] accNew;
  logic signed [TQ_W-1:0]  avg;
  logic signed [TQ_W-1:0]  res;
  logic [9:0]              fmt;

  assign diode2En = s_q.cfg2[CFG2_DIODE2_BIT];
  assign avgOff   = s_q.cfg2[CFG2_AVGOFF_BIT];
  assign extRange = s_q.cfg1[CFG1_RANGE_BIT];

  // Two differences from the four bias samples
  assign dv1 = $signed({s_q.smp[1][ADC_W-1], s_q.smp[1]})
             - $signed({s_q.smp[0][ADC_W-1], s_q.smp[0]});
  assign dv2 = $signed({s_q.smp[3][ADC_W-1], s_q.smp[3]})
             - $signed({s_q.smp[2][ADC_W-1], s_q.smp[2]});
  // Weights chosen so the IR drop term of the two steps subtracts out
  assign prod   = 32'(dv1) * DV1_GAIN - 32'(dv2) * DV2_GAIN;
  assign tq     = TQ_W'(prod >>> CALC_SHIFT);
  assign accNew = $signed(s_q.acc[s_q.ch]) + ACC_W'(tq);
  assign avg    = TQ_W'(accNew >>> AVG_LOG2);
  assign res    = avgOff ? tq : avg;
  assign fmt    = fmtTemp(res, extRange);

  always_comb begin
    s_d = s_q;
    s_d.adcStart = 1'b0;
    // Measurement sequencer, same for every channel
    case (s_q.st)
      ST_START: begin
        s_d.adcStart = 1'b1;
        s_d.st       = ST_WAIT;
      end
      ST_WAIT: begin
        if (adcDone) begin
          s_d.smp[s_q.step] = adcData;
          if (s_q.step == 2'(STEP_LAST)) begin
            s_d.st = ST_CALC;
          end else begin
            s_d.step = s_q.step + 2'h1;
            s_d.st   = ST_START;
            // Base, N1, base, N2
            s_d.bias = s_q.step[0] ? (s_q.step[1] ? BIAS_BASE : BIAS_N2) : BIAS_N1;
            if (s_q.step == 2'h1) begin
              s_d.bias = BIAS_BASE;
            end
            if (s_q.step == 2'h2) begin
              s_d.bias = BIAS_N2;
            end
          end
        end
      end
      ST_CALC: begin
        if (avgOff || s_q.cnt[s_q.ch] == AVG_LOG2'(AVG_CNT - 1)) begin
          s_d.acc[s_q.ch] = '0;
          s_d.cnt[s_q.ch] = '0;
          case (s_q.ch)
            CH_LOCAL: begin
              s_d.locTemp = fmt[9:2];
              s_d.locFrac = fmt[1:0];
            end
            CH_REMOTE1: begin
              s_d.remTemp = fmt[9:2];
              s_d.remFrac = fmt[1:0];
            end
            default: s_d.rem2Temp = fmt[9:2];
          endcase
        end else begin
          s_d.acc[s_q.ch] = ACC_W'(accNew);
          s_d.cnt[s_q.ch] = s_q.cnt[s_q.ch] + AVG_LOG2'(1);
        end
        // Local and remote one always; remote two only when enabled
        case (s_q.ch)
          CH_LOCAL:   s_d.ch = CH_REMOTE1;
          CH_REMOTE1: s_d.ch = diode2En ? CH_REMOTE2 : CH_LOCAL;
          default:    s_d.ch = CH_LOCAL;
        endcase
        s_d.step = 2'h0;
        s_d.bias = BIAS_BASE;
        s_d.st   = ST_START;
      end
      default: s_d.st = ST_START;
    endcase

    // Write channel: address and data taken in either order
    if (awvalid && awready) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.wHeld = 1'b1;
      s_d.wByte = wdata[7:0];
      s_d.wLane = wstrb[0];
    end
    if (s_q.awHeld && s_q.wHeld) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = isMapped(s_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wLane) begin
        case (s_q.awAddr)
          ADDR_CFG1: s_d.cfg1 = s_q.wByte;
          ADDR_CFG2: s_d.cfg2 = s_q.wByte;
          ADDR_CFG3: s_d.cfg3 = s_q.wByte;
          default:   s_d.cfg1 = s_d.cfg1;
        endcase
      end
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read channel
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = readReg(s_q, araddr);
      s_d.rresp  = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q      <= '0;
      s_q.st   <= ST_START;
      s_q.ch   <= CH_LOCAL;
      s_q.bias <= BIAS_BASE;
      s_q.cfg1 <= CFG1_RST;
      s_q.cfg2 <= CFG2_RST;
      s_q.cfg3 <= CFG3_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = !s_q.awHeld && !s_q.bvalid;
  assign wready  = !s_q.wHeld && !s_q.bvalid;
  assign bvalid  = s_q.bvalid;
  assign bresp   = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid  = s_q.rvalid;
  assign rdata   = s_q.rdata;
  assign rresp   = s_q.rresp;

  assign adcStart        = s_q.adcStart;
  assign biasSel         = s_q.bias;
  assign chanSel         = s_q.ch;
  assign secondDiodeMode = diode2En;
  // Diode mode takes both inputs; otherwise each thermistor bit acts alone
  assign analogInFirstThermistor  = !diode2En && s_q.cfg3[CFG3_TH1_BIT];
  assign analogInSecondThermistor = !diode2En && s_q.cfg3[CFG3_TH2_BIT];
endmodule
`default_nettype wire

/* File: tmf_pkg.sv */
`default_nettype none
package tmf_pkg;
  // Register indices; byte address is four times the index
  localparam int        REG_STEP       = 4;
  localparam int        IDX_CFG1       = 'h00;
  localparam int        IDX_CFG2       = 'h01;
  localparam int        IDX_CFG3       = 'h02;
  localparam int        IDX_EXT_REMOTE = 'h08;
  localparam int        IDX_EXT_LOCAL  = 'h09;
  localparam int        IDX_REMOTE2    = 'h0A;
  localparam int        IDX_REMOTE     = 'h0D;
  localparam int        IDX_LOCAL      = 'h0E;
  localparam int        ADDR_W         = 8;
  localparam logic [7:0] ADDR_CFG1       = 8'(IDX_CFG1 * REG_STEP);
  localparam logic [7:0] ADDR_CFG2       = 8'(IDX_CFG2 * REG_STEP);
  localparam logic [7:0] ADDR_CFG3       = 8'(IDX_CFG3 * REG_STEP);
  localparam logic [7:0] ADDR_EXT_REMOTE = 8'(IDX_EXT_REMOTE * REG_STEP);
  localparam logic [7:0] ADDR_EXT_LOCAL  = 8'(IDX_EXT_LOCAL * REG_STEP);
  localparam logic [7:0] ADDR_REMOTE2    = 8'(IDX_REMOTE2 * REG_STEP);
  localparam logic [7:0] ADDR_REMOTE     = 8'(IDX_REMOTE * REG_STEP);
  localparam logic [7:0] ADDR_LOCAL      = 8'(IDX_LOCAL * REG_STEP);
  // Field positions
  localparam int        CFG1_RANGE_BIT  = 7;
  localparam int        CFG2_DIODE2_BIT = 7;
  localparam int        CFG2_AVGOFF_BIT = 4;
  localparam int        CFG3_TH1_BIT    = 7;
  localparam int        CFG3_TH2_BIT    = 6;
  // Reset values
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] CFG3_RST = 8'hC0;
  // Formatting and averaging
  localparam int        FRAC_W     = 2;
  localparam int        AVG_LOG2   = 4;
  localparam int        AVG_CNT    = 16;
  localparam int        EXT_OFFSET = 64;
  localparam int        BIN_MAX    = 127;
  localparam int        EXT_MAX    = 255;
  localparam int        STEP_LAST  = 3;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_START = 3'h1,
    ST_WAIT  = 3'h2,
    ST_CALC  = 3'h4
  } tmf_state_e;
  typedef enum logic [1:0] {
    CH_LOCAL   = 2'h0,
    CH_REMOTE1 = 2'h1,
    CH_REMOTE2 = 2'h2
  } tmf_chan_e;
  typedef enum logic [1:0] {
    BIAS_BASE = 2'h0,
    BIAS_N1   = 2'h1,
    BIAS_N2   = 2'h2
  } tmf_bias_e;
endpackage
`default_nettype wire

/* File: tmf_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module tmf_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Front end
  input wire logic        adcStart,
  input wire logic        adcDone,
  input wire logic [1:0]  biasSel,
  input wire logic [1:0]  chanSel,
  input wire logic        secondDiodeMode,
  input wire logic        analogInFirstThermistor,
  input wire logic        analogInSecondThermistor,
  // Read channel
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  import tmf_pkg::*;
  logic       waitQ;
  logic [1:0] lastBiasQ;
  logic [1:0] lastNQ;
  logic [1:0] lastChanQ;
  always_ff @(posedge clk) begin
    if (rst) begin
      waitQ <= 1'b0;
      lastBiasQ <= BIAS_N2;
      lastNQ <= BIAS_N2;
      lastChanQ <= CH_LOCAL;
    end else if (adcStart) begin
      waitQ <= 1'b1;
      lastBiasQ <= biasSel;
      lastChanQ <= chanSel;
      if (biasSel != BIAS_BASE) begin
        lastNQ <= biasSel;
      end
    end else if (adcDone) begin
      waitQ <= 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_START_AFTER_RST: assert property ($fell(rst) |-> ##[0:2] adcStart)
    else $error("no conversion start after reset");
  AST_START_PULSE: assert property (adcStart |=> !adcStart)
    else $error("start longer than one cycle");
  AST_SEL_HOLD: assert property (waitQ && !adcStart |-> $stable(biasSel) && $stable(chanSel))
    else $error("selection moved during conversion");
  AST_BIAS_ORDER: assert property (adcStart && biasSel != BIAS_BASE |-> lastBiasQ == BIAS_BASE && biasSel != lastNQ)
    else $error("bias step out of order");
  AST_BASE_ALT: assert property (adcStart && biasSel == BIAS_BASE |-> lastBiasQ != BIAS_BASE)
    else $error("base current twice in a row");
  AST_CHAN_SWITCH: assert property (adcStart && chanSel != lastChanQ |-> biasSel == BIAS_BASE && lastBiasQ == BIAS_N2)
    else $error("channel switched mid sequence");
  AST_REM2_MODE: assert property (adcStart && chanSel == CH_REMOTE2 |-> secondDiodeMode)
    else $error("second diode measured while off");
  AST_TH_OFF: assert property (secondDiodeMode |-> !analogInFirstThermistor && !analogInSecondThermistor)
    else $error("thermistor mode with second diode");
  AST_TH_DEFAULT: assert property ($fell(rst) |-> analogInFirstThermistor && analogInSecondThermistor && !secondDiodeMode)
    else $error("input modes wrong after reset");
  AST_RDATA_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  AST_RDATA_BYTE: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read upper bits not zero");
  cover property (adcStart && chanSel == CH_REMOTE2);
  cover property (adcStart && biasSel == BIAS_N2 && chanSel == CH_REMOTE1);
  cover property (rvalid && rresp == RESP_SLVERR);
  cover property (rvalid && !rready);
endmodule
bind tmf_temperature_measure_format tmf_properties tmf_properties_i (
  .clk(clk), .rst(rst), .adcStart(adcStart), .adcDone(adcDone),
  .biasSel(biasSel), .chanSel(chanSel), .secondDiodeMode(secondDiodeMode),
  .analogInFirstThermistor(analogInFirstThermistor),
  .analogInSecondThermistor(analogInSecondThermistor),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
);
`default_nettype wire

/* File: tmf_front_end_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tmf_front_end_model (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Conversion request
  input  wire logic               adcStart,
  input  wire logic [1:0]         biasSel,
  input  wire logic [1:0]         chanSel,
  // Sensed temperatures in quarter degrees
  input  wire logic signed [11:0] tqLoc,
  input  wire logic signed [11:0] tqRem,
  input  wire logic signed [11:0] tqRem2,
  input  wire logic               slow,
  input  wire logic               jitter,
  // Conversion answer
  output logic                    adcDone,
  output logic [15:0]             adcData
);
  logic [3:0]         waitQ;
  logic               busyQ;
  logic [2:0]         parQ;
  logic signed [15:0] v;
  // Both steps give the same difference so the weighted result equals v
  always_comb begin
    v = 16'(chanSel == 2'h0 ? tqLoc : chanSel == 2'h1 ? tqRem : tqRem2);
    if (jitter) begin
      v = parQ[chanSel] ? v + 16'sh4 : v - 16'sh4;
    end
  end
  always_ff @(posedge clk) begin
    adcDone <= 1'b0;
    adcData <= ~adcData;
    if (rst) begin
      busyQ <= 1'b0;
      parQ <= 3'h0;
      adcData <= 16'h0;
    end else if (adcStart) begin
      busyQ <= 1'b1;
      waitQ <= slow ? 4'h9 : 4'h0;
      if (biasSel == 2'h1) begin
        parQ[chanSel] <= ~parQ[chanSel];
      end
    end else if (busyQ && waitQ == 4'h0) begin
      busyQ <= 1'b0;
      adcDone <= 1'b1;
      adcData <= biasSel == 2'h0 ? 16'h0 : v;
    end else if (busyQ) begin
      waitQ <= waitQ - 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: test_temperature_measure_format.sv */
`timescale 1ns/1ps
`default_nettype none
module test_temperature_measure_format;
  import tmf_pkg::*;
  logic clk = 0, rst = 1, slow = 0, jitter = 0, adcDone;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, adcStart, secondDiodeMode;
  logic analogInFirstThermistor, analogInSecondThermistor;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, biasSel, chanSel;
  logic [15:0] adcData;
  logic [2:0]  inMode;
  logic signed [11:0] tq [3];
  logic [11:0] corner [7] = '{12'hED4, 12'hFF8, 12'h000, 12'h003, 12'h1FE, 12'h200, 12'h7FF};
  int n_mismatch = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  assign inMode = {secondDiodeMode, analogInFirstThermistor, analogInSecondThermistor};
  tmf_temperature_measure_format tmf_temperature_measure_format_i (.clk, .rst, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .adcStart, .biasSel, .chanSel,
    .secondDiodeMode, .analogInFirstThermistor, .analogInSecondThermistor, .adcDone, .adcData);
  tmf_front_end_model tmf_front_end_model_i (.clk, .rst, .adcStart, .biasSel, .chanSel,
    .tqLoc(tq[0]), .tqRem(tq[1]), .tqRem2(tq[2]), .slow, .jitter, .adcDone, .adcData);
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er,
                    input logic [3:0] s = 4'hF);
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    cmp(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic hs;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    // A late ready makes the slave hold its answer for a cycle
    rready <= 1'($urandom_range(1));
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      hs = rvalid && rready;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!hs);
    cmp(rdata, e);
    cmp(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask
  function automatic logic [9:0] fmt(input logic signed [11:0] t, input logic ofs);
    int v;
    v = int'(t >>> 2) + (ofs ? EXT_OFFSET : 0);
    if (v < 0 || (!ofs && t <= 0)) return 10'h0;
    if (v > (ofs ? EXT_MAX : BIN_MAX)) return {8'(ofs ? EXT_MAX : BIN_MAX), 2'h0};
    return {8'(v), t[1:0]};
  endfunction
  task automatic chk_res(input logic ofs, input logic rem2);
    logic [9:0] e;
    e = fmt(tq[0], ofs);
    rc(ADDR_LOCAL, 32'(e[9:2]), RESP_OKAY);
    rc(ADDR_EXT_LOCAL, 32'(e[1:0]), RESP_OKAY);
    e = fmt(tq[1], ofs);
    rc(ADDR_REMOTE, 32'(e[9:2]), RESP_OKAY);
    rc(ADDR_EXT_REMOTE, 32'(e[1:0]), RESP_OKAY);
    e = fmt(tq[2], ofs);
    if (rem2) rc(ADDR_REMOTE2, 32'(e[9:2]), RESP_OKAY);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk iff adcStart);
    repeat (4) @(posedge clk);
  endtask
  task automatic new_temps(input logic [11:0] t0);
    @(posedge clk);
    tq[0] <= t0;
    tq[1] <= 12'($urandom_range(1300) - 250);
    tq[2] <= 12'($urandom_range(1300) - 250);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h34b97858));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc(ADDR_CFG1, 32'(CFG1_RST), RESP_OKAY);
    rc(ADDR_CFG3, 32'(CFG3_RST), RESP_OKAY);
    rc(8'hFC, 32'h0, RESP_SLVERR);
    wr(8'hFC, 8'h11, RESP_SLVERR);
    // Lane zero strobe low leaves the register untouched
    wr(ADDR_CFG1, 8'h80, RESP_OKAY, 4'h0);
    rc(ADDR_CFG1, 32'(CFG1_RST), RESP_OKAY);
    wr(ADDR_CFG2, 8'h10, RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      if (i == 8) wr(ADDR_CFG1, 8'h80, RESP_OKAY);
      if (i == 12) wr(ADDR_CFG2, 8'h90, RESP_OKAY);
      slow <= i[0];
      new_temps(i % 8 < 7 ? corner[i % 8] : 12'($urandom_range(1300) - 250));
      settle(24);
      wr(ADDR_LOCAL, 8'hAA, RESP_OKAY);
      chk_res(i >= 8, i >= 12);
      if (i == 12) cmp(32'(inMode), 32'h4);
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(ADDR_CFG2, 32'(CFG2_RST), RESP_OKAY);
    cmp(32'(inMode), 32'h3);
    wr(ADDR_CFG3, 8'h40, RESP_OKAY);
    cmp(32'(inMode), 32'h1);
    jitter <= 1'b1;
    // Local kept off both clamps so an unaveraged result shows up
    new_temps(12'($urandom_range(480, 20)));
    settle(400);
    chk_res(1'b0, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
